// [rtl/dbfs_defs.vh]
/*
 * Constants for the dual breaker fault sequencer: timing figures, derived
 * cycle counts, state codes and delay select encodings.
 * Assumes a 10 MHz clock; all comparator inputs synchronous to it.
 */
// Operation
// - Fault flag released only when switch fully on
// - Flag asserted on disable, limit, heat, watchdog, config
// - Enable active high, defaults high, low turns off
// - Shutdown delay selectable: 12us, 100us, 1ms, 10ms
// - Watchdog starts when startup phase begins
// - Output near input ends startup, releases flag
// - Watchdog expiry while far: off, fault state
// - Watchdog timeout is 250ms
// - Auto-retry restarts full power-up after retry wait
// - Latch-off holds until enable toggles or undervoltage cycles
// - Thermal shutdown active always, switches off immediately
// - Undervoltage switches off immediately, asserts flag
// - Constant power until near, then constant current
// - Fully on selects normal current limit reference
// - Fast overcurrent trips off within 200ns (acted on only when fully on, ignored in startup)
// - Input and enable debounced before turn-on
// - Ramp only after steady enable and input, startup only
// - Near at enable means short: off, fault state
// - Delay timer counts up at limit, down slower
// - Retry cycle repeats with flag held asserted
`ifndef DBFS_DEFS_VH
`define DBFS_DEFS_VH

`define DBFS_CLK_MHZ        10
`define DBFS_WDOG_MS        250
`define DBFS_WDOG_CYC       (`DBFS_WDOG_MS * 1000 * `DBFS_CLK_MHZ)
`define DBFS_DEB_MS         16
`define DBFS_DEB_CYC        (`DBFS_DEB_MS * 1000 * `DBFS_CLK_MHZ)
`define DBFS_DLY0_US        12
`define DBFS_DLY1_US        100
`define DBFS_DLY2_US        1000
`define DBFS_DLY3_US        10000
`define DBFS_DLY0_CYC       (`DBFS_DLY0_US * `DBFS_CLK_MHZ)
`define DBFS_DLY1_CYC       (`DBFS_DLY1_US * `DBFS_CLK_MHZ)
`define DBFS_DLY2_CYC       (`DBFS_DLY2_US * `DBFS_CLK_MHZ)
`define DBFS_DLY3_CYC       (`DBFS_DLY3_US * `DBFS_CLK_MHZ)
`define DBFS_RETRY_MULT     60
`define DBFS_DOWN_DIV       4
`define DBFS_CW             32

`define DBFS_ST_OFF         6'h01
`define DBFS_ST_QUAL        6'h02
`define DBFS_ST_CHECK       6'h04
`define DBFS_ST_START       6'h08
`define DBFS_ST_RUN         6'h10
`define DBFS_ST_FAULT       6'h20

`endif

// [rtl/dbfs_chan.v]
/*
 * One breaker channel: qualification, startup, run and fault states,
 * shutdown-delay integrator and retry timer.
 * Assumes comparator levels synchronous to clk, timing counts from the top.
 */
`timescale 1ns/100ps
`include "dbfs_defs.vh"

module dbfs_chan
#(
    parameter [31:0] DEB_CYC  = `DBFS_DEB_CYC,
    parameter [31:0] WDOG_CYC = `DBFS_WDOG_CYC
)
(
    input  wire        clk,
    input  wire        resetn,
    input  wire        turn_on,
    input  wire        uv_ok,
    input  wire        over_temp,
    input  wire        near_in,
    input  wire        at_limit,
    input  wire        fast_trip,
    input  wire        auto_retry,
    input  wire [31:0] delay_cyc,
    output reg         switch_on_r,
    output reg         fault_flag_n_r,
    output reg         const_current_r,
    output reg         normal_limit_r
);

    reg [5:0]  state_r;
    reg [5:0]  state_nxt;
    reg [31:0] tmr_r;
    reg [31:0] tmr_nxt;
    reg [31:0] dly_r;
    reg [31:0] dly_nxt;
    reg [1:0]  div_r;
    reg        latch_r;
    reg        en_seen_low_r;
    reg        uv_seen_low_r;

    wire kill = over_temp | ~uv_ok | ~turn_on;
    wire retry_done = tmr_r >= (delay_cyc * `DBFS_RETRY_MULT);

    always @*
    begin
        state_nxt = state_r;
        tmr_nxt   = tmr_r + 32'h00000001;
        dly_nxt   = dly_r;
        case (state_r)
            `DBFS_ST_OFF:
            begin
                tmr_nxt = 32'h00000000;
                if (turn_on && uv_ok && !over_temp)
                    state_nxt = `DBFS_ST_QUAL;
            end
            `DBFS_ST_QUAL:
            begin
                // Steady enable and input for the filter time
                if (kill)
                begin
                    state_nxt = `DBFS_ST_OFF;
                    tmr_nxt   = 32'h00000000;
                end
                else if (tmr_r >= DEB_CYC)
                begin
                    state_nxt = `DBFS_ST_CHECK;
                    tmr_nxt   = 32'h00000000;
                end
            end
            `DBFS_ST_CHECK:
            begin
                tmr_nxt = 32'h00000000;
                if (kill)
                    state_nxt = `DBFS_ST_OFF;
                else if (near_in)
                    state_nxt = `DBFS_ST_FAULT;
                else
                    state_nxt = `DBFS_ST_START;
            end
            `DBFS_ST_START:
            begin
                if (kill)
                    state_nxt = `DBFS_ST_OFF;
                else if (near_in)
                begin
                    state_nxt = `DBFS_ST_RUN;
                    dly_nxt   = 32'h00000000;
                end
                else if (tmr_r >= WDOG_CYC - 32'h00000001)
                begin
                    state_nxt = `DBFS_ST_FAULT;
                    tmr_nxt   = 32'h00000000;
                end
            end
            `DBFS_ST_RUN:
            begin
                tmr_nxt = 32'h00000000;
                if (at_limit)
                    dly_nxt = dly_r + 32'h00000001;
                else if (dly_r != 32'h00000000 && div_r == 2'h0)
                    dly_nxt = dly_r - 32'h00000001;
                if (kill)
                    state_nxt = `DBFS_ST_OFF;
                else if (fast_trip || dly_nxt >= delay_cyc)
                    state_nxt = `DBFS_ST_FAULT;
            end
            `DBFS_ST_FAULT:
            begin
                if (over_temp)
                    tmr_nxt = 32'h00000000;
                if (latch_r)
                begin
                    tmr_nxt = 32'h00000000;
                    if ((en_seen_low_r || uv_seen_low_r) && turn_on && uv_ok)
                        state_nxt = `DBFS_ST_OFF;
                end
                else if (retry_done && !over_temp && turn_on && uv_ok)
                begin
                    state_nxt = `DBFS_ST_QUAL;
                    tmr_nxt   = 32'h00000000;
                end
            end
            default:
            begin
                state_nxt = `DBFS_ST_OFF;
            end
        endcase
    end

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            state_r         <= `DBFS_ST_OFF;
            tmr_r           <= 32'h00000000;
            dly_r           <= 32'h00000000;
            div_r           <= 2'h0;
            latch_r         <= 1'b0;
            en_seen_low_r   <= 1'b0;
            uv_seen_low_r   <= 1'b0;
            switch_on_r     <= 1'b0;
            fault_flag_n_r  <= 1'b0;
            const_current_r <= 1'b0;
            normal_limit_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            tmr_r   <= tmr_nxt;
            dly_r   <= dly_nxt;
            div_r   <= div_r + 2'h1;
            if (state_nxt == `DBFS_ST_FAULT && state_r != `DBFS_ST_FAULT)
            begin
                latch_r       <= ~auto_retry;
                en_seen_low_r <= 1'b0;
                uv_seen_low_r <= 1'b0;
            end
            else
            begin
                if (!turn_on)
                    en_seen_low_r <= 1'b1;
                if (!uv_ok)
                    uv_seen_low_r <= 1'b1;
            end
            switch_on_r     <= (state_nxt == `DBFS_ST_START) ||
                               (state_nxt == `DBFS_ST_RUN);
            fault_flag_n_r  <= (state_nxt == `DBFS_ST_RUN) && !at_limit;
            const_current_r <= (state_nxt == `DBFS_ST_RUN);
            normal_limit_r  <= (state_nxt == `DBFS_ST_RUN);
        end
    end

endmodule // dbfs_chan

// [rtl/dbfs_top.v]
/*
 * Dual breaker fault sequencer: two channel sequencers plus delay select.
 * Assumes all inputs synchronous to the 10 MHz clk; enables pulled high
 * outside when undriven.
 */
`timescale 1ns/100ps
`include "dbfs_defs.vh"

module dbfs_top
#(
    parameter [31:0] DEB_CYC  = `DBFS_DEB_CYC,
    parameter [31:0] WDOG_CYC = `DBFS_WDOG_CYC
)
(
    input  wire       clk,
    input  wire       resetn,
    input  wire       ch1_turn_on,
    input  wire       ch2_turn_on,
    input  wire       parallel_mode,
    input  wire       auto_retry_mode,
    input  wire [1:0] shutdown_delay_select,
    input  wire       undervoltage_ok,
    input  wire       over_temp,
    input  wire [1:0] near_input,
    input  wire [1:0] at_current_limit,
    input  wire [1:0] fast_overcurrent,
    output wire [1:0] switch_on,
    output wire       ch1_fault_flag_n,
    output wire       ch2_fault_flag_n,
    output wire [1:0] const_current_mode,
    output wire [1:0] normal_limit_sel
);

    reg  [31:0] delay_cyc;
    wire [1:0]  en_vec;
    wire [1:0]  flag_n;

    // Parallel: channel 2 follows channel 1 enable
    assign en_vec = {parallel_mode ? ch1_turn_on : ch2_turn_on, ch1_turn_on};

    always @*
    begin
        case (shutdown_delay_select)
            2'h0:    delay_cyc = `DBFS_DLY0_CYC;
            2'h1:    delay_cyc = `DBFS_DLY1_CYC;
            2'h2:    delay_cyc = `DBFS_DLY2_CYC;
            default: delay_cyc = `DBFS_DLY3_CYC;
        endcase
    end

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1)
        begin : g_ch
            dbfs_chan #(
                .DEB_CYC  (DEB_CYC),
                .WDOG_CYC (WDOG_CYC)
            ) u_chan (
                .clk             (clk),
                .resetn          (resetn),
                .turn_on         (en_vec[i]),
                .uv_ok           (undervoltage_ok),
                .over_temp       (over_temp),
                .near_in         (near_input[i]),
                .at_limit        (at_current_limit[i]),
                .fast_trip       (fast_overcurrent[i]),
                .auto_retry      (auto_retry_mode),
                .delay_cyc       (delay_cyc),
                .switch_on_r     (switch_on[i]),
                .fault_flag_n_r  (flag_n[i]),
                .const_current_r (const_current_mode[i]),
                .normal_limit_r  (normal_limit_sel[i])
            );
        end
    endgenerate

    assign ch1_fault_flag_n = flag_n[0];
    assign ch2_fault_flag_n = flag_n[1];

endmodule // dbfs_top

// [bench/dbfs_board.sv]
/* Board side enable drivers for the breaker sequencer.
   Assumes the bench asks for a channel off by pulling it low. */
`timescale 1ns/100ps
module dbfs_board (
    input  logic [1:0] pull_low,
    output logic       en1,
    output logic       en2
);
    // Undriven enables read high
    assign en1 = !pull_low[0];
    assign en2 = !pull_low[1];
endmodule // dbfs_board

// [bench/dbfs_top_chk.sv]
/* Port assertions for the breaker sequencer, bound into dbfs_top.
   Assumes the sync active-low reset and the top's timing parameters. */
`timescale 1ns/100ps
module dbfs_top_chk #(
    parameter [31:0] DEB_CYC  = 32'h00027100,
    parameter [31:0] WDOG_CYC = 32'h002625A0
) (
    input logic       clk,
    input logic       resetn,
    input logic       ch1_turn_on,
    input logic       undervoltage_ok,
    input logic       over_temp,
    input logic [1:0] near_input,
    input logic [1:0] at_current_limit,
    input logic [1:0] fast_overcurrent,
    input logic [1:0] switch_on,
    input logic       ch1_fault_flag_n,
    input logic       ch2_fault_flag_n,
    input logic [1:0] normal_limit_sel
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    logic [31:0] qcnt_r;
    logic [31:0] scnt_r;
    always_ff @(posedge clk)
    begin
        if (!resetn || !(ch1_turn_on && undervoltage_ok))
            qcnt_r <= 32'h0;
        else if (qcnt_r != 32'hFFFFFFFF)
            qcnt_r <= qcnt_r + 32'h1;
        if (!resetn || !(switch_on[0] && !normal_limit_sel[0]))
            scnt_r <= 32'h0;
        else
            scnt_r <= scnt_r + 32'h1;
    end
    sequence s_kill;
        over_temp || !undervoltage_ok;
    endsequence
    sequence s_start_near;
        switch_on[0] && !normal_limit_sel[0] && near_input[0] && ch1_turn_on
            && undervoltage_ok && !over_temp && !fast_overcurrent[0];
    endsequence
    a_flag1_on: assert property (ch1_fault_flag_n |-> switch_on[0])
        else $error("flag1 released while off");
    a_flag2_on: assert property (ch2_fault_flag_n |-> switch_on[1])
        else $error("flag2 released while off");
    a_kill_off: assert property (s_kill |=> switch_on == 2'h0
        && !ch1_fault_flag_n && !ch2_fault_flag_n) else $error("kill missed");
    a_fast_trip: assert property (fast_overcurrent[0] && normal_limit_sel[0]
        |=> !switch_on[0]) else $error("fast trip missed");
    a_limit_flag: assert property (at_current_limit[0] && normal_limit_sel[0]
        |=> !ch1_fault_flag_n) else $error("limit flag missed");
    a_disable_off: assert property (!ch1_turn_on
        |=> !switch_on[0] && !ch1_fault_flag_n) else $error("disable missed");
    a_near_run: assert property (s_start_near |=> normal_limit_sel[0])
        else $error("startup not ended");
    a_deb_wait: assert property ($rose(switch_on[0])
        |-> qcnt_r >= DEB_CYC) else $error("turn on before debounce");
    a_wdog_bound: assert property (scnt_r <= WDOG_CYC + 32'h1)
        else $error("startup too long");
endmodule // dbfs_top_chk

bind dbfs_top dbfs_top_chk #(.DEB_CYC(DEB_CYC), .WDOG_CYC(WDOG_CYC)) i_chk (
    .clk, .resetn, .ch1_turn_on, .undervoltage_ok, .over_temp, .near_input,
    .at_current_limit, .fast_overcurrent, .switch_on, .ch1_fault_flag_n,
    .ch2_fault_flag_n, .normal_limit_sel
);

// [bench/dbfs_top_tb.sv]
/* Self-checking bench for dbfs_top: startup, faults, retry and kills.
   Assumes debounce 20 and watchdog 200 cycles, delay select 12us then 100us. */
`timescale 1ns/100ps
module dbfs_top_tb;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic [1:0] pl = 2'h0;
    logic [1:0] nr = 2'h0;
    logic [1:0] lim = 2'h0;
    logic [1:0] fst = 2'h0;
    logic       par = 1'b0;
    logic       ar = 1'b0;
    logic       uv = 1'b1;
    logic       ot = 1'b0;
    logic [1:0] ds = 2'h0;
    logic [1:0] cc;
    logic       en1;
    logic       en2;
    logic [1:0] sw;
    logic [1:0] flg;
    logic [1:0] nl;
    int         err_count = 0;
    int         check_count = 0;

    always #50 clk = !clk;

    dbfs_board i_board (.pull_low(pl), .en1(en1), .en2(en2));
    dbfs_top #(.DEB_CYC(32'h14), .WDOG_CYC(32'hC8)) i_dut (
        .clk(clk), .resetn(resetn), .ch1_turn_on(en1), .ch2_turn_on(en2),
        .parallel_mode(par), .auto_retry_mode(ar), .shutdown_delay_select(ds),
        .undervoltage_ok(uv), .over_temp(ot), .near_input(nr),
        .at_current_limit(lim), .fast_overcurrent(fst), .switch_on(sw),
        .ch1_fault_flag_n(flg[0]), .ch2_fault_flag_n(flg[1]),
        .const_current_mode(cc), .normal_limit_sel(nl)
    );

    task final_report;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task chk(input logic [3:0] g, input logic [3:0] e, input string s);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, s);
        end
    endtask

    // Bounded wait for masked switch state
    task automatic wsw(input logic [1:0] m, input logic [1:0] e, input int n);
        for (int i = 0; i < n && (sw & m) !== e; i++)
            tick(1);
        chk({2'h0, sw & m}, {2'h0, e}, "switch wait");
        if ((sw & m) !== e)
            final_report();
    endtask

    task tog;
        pl[0] = 1'b1;
        tick(2);
        chk({2'h0, flg & 2'h1}, 4'h0, "disabled flag");
        pl[0] = 1'b0;
    endtask

    initial
    begin
        tick(10);
        resetn = 1'b1;
        chk({2'h0, en2, en1}, 4'h3, "enable default");
        tick(15);
        chk({flg, sw}, 4'h0, "early turn on");
        wsw(2'h3, 2'h3, 20);
        chk({flg, sw}, 4'h3, "flag in startup");
        chk({cc, nl}, 4'h0, "startup regime");
        nr = 2'h3;
        tick(2);
        chk({flg, nl}, 4'hF, "startup end");
        chk({cc, sw}, 4'hF, "run regime");
        lim[0] = 1'b1;
        tick(100);
        chk({flg, sw}, 4'hB, "early shutdown");
        wsw(2'h1, 2'h0, 40);
        lim[0] = 1'b0;
        tick(300);
        chk({flg, sw}, 4'hA, "latched");
        tog;
        tick(60);
        chk({flg, sw}, 4'hA, "short at check");
        nr[0] = 1'b0;
        tog;
        wsw(2'h1, 2'h1, 40);
        tick(150);
        chk({flg, sw}, 4'hB, "watchdog early");
        wsw(2'h1, 2'h0, 80);
        ar = 1'b1;
        tog;
        wsw(2'h1, 2'h1, 40);
        wsw(2'h1, 2'h0, 240);
        tick(7000);
        chk({flg, sw}, 4'hA, "retry wait");
        wsw(2'h1, 2'h1, 400);
        nr[0] = 1'b1;
        tick(2);
        fst[0] = 1'b1;
        tick(2);
        chk({flg, sw}, 4'hA, "fast trip");
        fst[0] = 1'b0;
        uv = 1'b0;
        tick(2);
        chk({flg, sw}, 4'h0, "undervoltage");
        uv = 1'b1;
        nr = 2'h0;
        wsw(2'h2, 2'h2, 40);
        nr[1] = 1'b1;
        tick(2);
        ot = 1'b1;
        tick(2);
        chk({flg, sw}, 4'h0, "thermal");
        ot = 1'b0;
        nr = 2'h0;
        par = 1'b1;
        pl = 2'h2;
        wsw(2'h2, 2'h2, 40);
        // Delay 100us: limit 600, relax 400 (down 100), limit 500 more
        ar = 1'b0;
        ds = 2'h1;
        nr[1] = 1'b1;
        tick(2);
        chk({cc, nl}, 4'hA, "ch2 run regime");
        lim[1] = 1'b1;
        tick(600);
        lim[1] = 1'b0;
        tick(400);
        lim[1] = 1'b1;
        tick(499);
        chk({flg, sw}, 4'h2, "slow countdown");
        tick(1);
        chk({flg, sw}, 4'h0, "delay 100us");
        lim[1] = 1'b0;
        nr = 2'h0;
        tick(50);
        chk({flg, sw}, 4'h0, "ch2 latched");
        uv = 1'b0;
        tick(2);
        uv = 1'b1;
        wsw(2'h2, 2'h2, 40);
        final_report();
    end
endmodule // dbfs_top_tb
